/* core/osl_cfg.svh */
/*
 Register offsets, bit positions and response codes of the output line
 source selector. Assumes AXI4-Lite with 32-bit data and byte addresses.
*/
`ifndef OSL_CFG_SVH
`define OSL_CFG_SVH

// register byte offsets, one aligned word each
`define OSL_OFF_CTRL     8'h00
`define OSL_OFF_SRC_GP   8'h04
`define OSL_OFF_SRC_SP   8'h08
`define OSL_OFF_LVL_SEL  8'h0C
`define OSL_OFF_LVL_ONE  8'h10
`define OSL_OFF_LVL_ALL  8'h14
`define OSL_OFF_SEQ_SEL  8'h18
`define OSL_OFF_SEQ_ONE  8'h1C
`define OSL_OFF_SEQ_ALL  8'h20
`define OSL_OFF_SET_SEL  8'h24
`define OSL_OFF_STATUS   8'h28

// bit positions in the combined level words
`define OSL_BIT_GP       0
`define OSL_BIT_SP       12

// control word fields
`define OSL_CTRL_OUT     0
`define OSL_CTRL_INV_GP  1
`define OSL_CTRL_INV_SP  2

// status word: lsb of the active set index
`define OSL_STAT_SET_LSB 8

// reset values and bus answers
`define OSL_RST_LEVEL    2'h0
`define OSL_RESP_OKAY    2'h0
`define OSL_RESP_SLVERR  2'h2

`endif

/* core/osl_pkg.sv */
/*
 Types of the output line source selector.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package osl_pkg;

	// source choices for one output line
	typedef enum logic [2:0] {
		SRC_ACQ_WAIT   = 3'h0,
		SRC_FRAME_WAIT = 3'h1,
		SRC_EXPOSURE   = 3'h2,
		SRC_FRAME_CYC  = 3'h3,
		SRC_USER       = 3'h4,
		SRC_SYNC_USER  = 3'h5
	} osl_source_e;

endpackage : osl_pkg

/* core/osl_set_mem.sv */
/*
 Small memory holding the sequenced levels of every sequencer set.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none

module osl_set_mem #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 2
) (
	// clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     reset_n,
	// write port, per-bit enables
	input  wire logic [WIDTH-1:0]         wrEn,
	input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
	input  wire logic [WIDTH-1:0]         wrData,
	// read port, data one cycle later
	input  wire logic                     rdEn,
	input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
	output logic      [WIDTH-1:0]         rdData
);

	logic [WIDTH-1:0] store [DEPTH];
	logic [WIDTH-1:0] merged;

	// a single set would leave the address ports without any bits
	if (DEPTH < 2 || WIDTH < 1)
	begin : g_bad_param
		$error("osl_set_mem: DEPTH must be at least 2 and WIDTH at least 1");
	end

	// a same-cycle write is folded in so a load never sees stale levels
	assign merged = (store[wrAddr] & ~wrEn) | (wrData & wrEn);

	// storage, cleared at reset so every set starts low
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < DEPTH; i++)
			begin
				store[i] <= '0;
			end
		end
		else if (|wrEn)
		begin
			store[wrAddr] <= merged;
		end
	end

	// registered read
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rdData <= '0;
		end
		else if (rdEn)
		begin
			rdData <= (|wrEn && rdAddr == wrAddr) ? merged : store[rdAddr];
		end
	end

endmodule : osl_set_mem

`default_nettype wire

/* core/osl_top.sv */
/*
 Output line source selector: one general-purpose pin and one spare
 bit of the video link, each with its own source, static and sequenced
 user levels and inversion, behind an AXI4-Lite slave.
 Assumes camera status inputs and the sequencer advance are synchronous
 to sys_clk; the pin's input path and pad live elsewhere.
*/
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none

`include "osl_cfg.svh"

module osl_top #(
	parameter int NUM_SETS = 16,
	parameter int ADDR_W   = 8
) (
	// clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        reset_n,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// axi4-lite write response
	output logic      [1:0]                  s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0]           s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	// axi4-lite read data
	output logic      [31:0]                 s_axi_rdata,
	output logic      [1:0]                  s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// camera status signals
	input  wire logic                        acqTriggerWait,
	input  wire logic                        frameTriggerWait,
	input  wire logic                        exposureActive,
	input  wire logic                        frameCycle,
	// sequencer advance on frame start
	input  wire logic                        frameStartAdvance,
	input  wire logic [$clog2(NUM_SETS)-1:0] nextSetIndex,
	// output lines
	output logic                             generalPurposePin,
	output logic                             generalPurposePinEn,
	output logic                             spareLinkBit
);

	localparam int SET_W = $clog2(NUM_SETS);

	// refuse sizes the status word or the decode cannot carry
	if (NUM_SETS < 2 || NUM_SETS > 256 || ADDR_W < 8)
	begin : g_bad_param
		$error("osl_top: NUM_SETS must be 2..256 and ADDR_W at least 8");
	end

	// decode shared by the read and write paths
	function automatic logic isMapped(input logic [7:0] a);
		case ({a[7:2], 2'b00})
			`OSL_OFF_CTRL, `OSL_OFF_SRC_GP, `OSL_OFF_SRC_SP, `OSL_OFF_LVL_SEL,
			`OSL_OFF_LVL_ONE, `OSL_OFF_LVL_ALL, `OSL_OFF_SEQ_SEL,
			`OSL_OFF_SEQ_ONE, `OSL_OFF_SEQ_ALL, `OSL_OFF_SET_SEL,
			`OSL_OFF_STATUS: isMapped = 1'b1;
			default: isMapped = 1'b0;
		endcase
	endfunction : isMapped

	// level a line shows before inversion, for either line
	function automatic logic pickSource(
		input osl_pkg::osl_source_e s,
		input logic [3:0]           cam,
		input logic                 usr,
		input logic                 seq
	);
		case (s)
			osl_pkg::SRC_ACQ_WAIT:   pickSource = cam[0];
			osl_pkg::SRC_FRAME_WAIT: pickSource = cam[1];
			osl_pkg::SRC_EXPOSURE:   pickSource = cam[2];
			osl_pkg::SRC_FRAME_CYC:  pickSource = cam[3];
			osl_pkg::SRC_USER:       pickSource = usr;
			osl_pkg::SRC_SYNC_USER:  pickSource = seq;
			default:                 pickSource = 1'b0;
		endcase
	endfunction : pickSource

	// bus slave state
	logic                 awReady_reg;
	logic                 awHeld_reg;
	logic [7:0]           awAddr_reg;
	logic                 wReady_reg;
	logic                 wHeld_reg;
	logic [31:0]          wData_reg;
	logic [3:0]           wStrb_reg;
	logic                 bValid_reg;
	logic [1:0]           bResp_reg;
	logic                 arReady_reg;
	logic                 rValid_reg;
	logic [31:0]          rData_reg;
	logic [1:0]           rResp_reg;
	logic                 wrFire;
	logic                 arFire;
	logic [7:0]           wrOff;
	logic [31:0]          rdWord;

	// line configuration and levels; index 0 general-purpose, 1 spare
	logic                 lineModeOut_reg;
	logic [1:0]           invert_reg;
	osl_pkg::osl_source_e src_reg [2];
	logic                 levelSel_reg;
	logic                 seqSel_reg;
	logic [SET_W-1:0]     editSet_reg;
	logic [1:0]           staticLevel_reg;
	logic [1:0]           seqActive_reg;
	logic [SET_W-1:0]     activeSet_reg;
	logic                 loadPending_reg;
	logic [SET_W-1:0]     pendingSet_reg;
	logic [1:0]           seqWrMask;
	logic [1:0]           seqWrData;
	logic [1:0]           memRdata;
	logic [1:0]           lineOut_reg;
	logic                 pinEn_reg;
	logic [3:0]           camSig;

	assign wrFire = awHeld_reg && wHeld_reg && !bValid_reg;
	assign arFire = s_axi_arvalid && arReady_reg;
	assign wrOff  = {awAddr_reg[7:2], 2'b00};
	assign camSig = {frameCycle, exposureActive, frameTriggerWait, acqTriggerWait};

	// write address channel; one write at a time keeps ordering trivial
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			awReady_reg <= 1'b0;
			awHeld_reg  <= 1'b0;
			awAddr_reg  <= 8'h00;
		end
		else if (s_axi_awvalid && awReady_reg)
		begin
			awReady_reg <= 1'b0;
			awHeld_reg  <= 1'b1;
			awAddr_reg  <= s_axi_awaddr[7:0];
		end
		else if (wrFire)
		begin
			awHeld_reg <= 1'b0;
		end
		else if (!awHeld_reg && !bValid_reg)
		begin
			awReady_reg <= 1'b1;
		end
	end

	// write data channel, taken independently of the address
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wReady_reg <= 1'b0;
			wHeld_reg  <= 1'b0;
			wData_reg  <= 32'h0000_0000;
			wStrb_reg  <= 4'h0;
		end
		else if (s_axi_wvalid && wReady_reg)
		begin
			wReady_reg <= 1'b0;
			wHeld_reg  <= 1'b1;
			wData_reg  <= s_axi_wdata;
			wStrb_reg  <= s_axi_wstrb;
		end
		else if (wrFire)
		begin
			wHeld_reg <= 1'b0;
		end
		else if (!wHeld_reg && !bValid_reg)
		begin
			wReady_reg <= 1'b1;
		end
	end

	// write response, unmapped offsets answer slverr
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bValid_reg <= 1'b0;
			bResp_reg  <= `OSL_RESP_OKAY;
		end
		else if (wrFire)
		begin
			bValid_reg <= 1'b1;
			bResp_reg  <= isMapped(awAddr_reg) ? `OSL_RESP_OKAY : `OSL_RESP_SLVERR;
		end
		else if (s_axi_bready)
		begin
			bValid_reg <= 1'b0;
		end
	end

	// line configuration registers
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lineModeOut_reg <= 1'b0;
			invert_reg      <= 2'b00;
			src_reg[0]      <= osl_pkg::SRC_USER;
			src_reg[1]      <= osl_pkg::SRC_USER;
			levelSel_reg    <= 1'b0;
			seqSel_reg      <= 1'b0;
			editSet_reg     <= '0;
		end
		else if (wrFire && wStrb_reg[0])
		begin
			case (wrOff)
				`OSL_OFF_CTRL:
				begin
					lineModeOut_reg <= wData_reg[`OSL_CTRL_OUT];
					invert_reg      <= {wData_reg[`OSL_CTRL_INV_SP], wData_reg[`OSL_CTRL_INV_GP]};
				end
				`OSL_OFF_SRC_GP:  src_reg[0]   <= osl_pkg::osl_source_e'(wData_reg[2:0]);
				`OSL_OFF_SRC_SP:  src_reg[1]   <= osl_pkg::osl_source_e'(wData_reg[2:0]);
				`OSL_OFF_LVL_SEL: levelSel_reg <= wData_reg[0];
				`OSL_OFF_SEQ_SEL: seqSel_reg   <= wData_reg[0];
				`OSL_OFF_SET_SEL: editSet_reg  <= wData_reg[SET_W-1:0];
				default: ;
			endcase
		end
	end

	// static levels, touched only by the bus, never by the sequencer
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			staticLevel_reg <= `OSL_RST_LEVEL;
		end
		else if (wrFire && wrOff == `OSL_OFF_LVL_ONE && wStrb_reg[0])
		begin
			staticLevel_reg[levelSel_reg] <= wData_reg[0];
		end
		else if (wrFire && wrOff == `OSL_OFF_LVL_ALL)
		begin
			// other bits of the word are dropped
			if (wStrb_reg[0])
			begin
				staticLevel_reg[0] <= wData_reg[`OSL_BIT_GP];
			end
			if (wStrb_reg[1])
			begin
				staticLevel_reg[1] <= wData_reg[`OSL_BIT_SP];
			end
		end
	end

	// sequenced level writes go to the set being edited
	always_comb
	begin
		seqWrMask = 2'b00;
		seqWrData = 2'b00;
		if (wrFire && wrOff == `OSL_OFF_SEQ_ONE && wStrb_reg[0])
		begin
			seqWrMask[seqSel_reg] = 1'b1;
			seqWrData[seqSel_reg] = wData_reg[0];
		end
		else if (wrFire && wrOff == `OSL_OFF_SEQ_ALL)
		begin
			seqWrMask = {wStrb_reg[1], wStrb_reg[0]};
			seqWrData = {wData_reg[`OSL_BIT_SP], wData_reg[`OSL_BIT_GP]};
		end
	end

	// one word of levels per sequencer set
	osl_set_mem #(
		.DEPTH (NUM_SETS),
		.WIDTH (2)
	) u_set_mem (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.wrEn    (seqWrMask),
		.wrAddr  (editSet_reg),
		.wrData  (seqWrData),
		.rdEn    (frameStartAdvance),
		.rdAddr  (nextSetIndex),
		.rdData  (memRdata)
	);

	// frame start: fetch the next set, load it one cycle later
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			loadPending_reg <= 1'b0;
			pendingSet_reg  <= '0;
		end
		else
		begin
			loadPending_reg <= frameStartAdvance;
			if (frameStartAdvance)
			begin
				pendingSet_reg <= nextSetIndex;
			end
		end
	end

	// active set levels; a write landing during the load is merged in
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			seqActive_reg <= `OSL_RST_LEVEL;
			activeSet_reg <= '0;
		end
		else if (loadPending_reg)
		begin
			activeSet_reg <= pendingSet_reg;
			seqActive_reg <= (editSet_reg == pendingSet_reg) ?
				((memRdata & ~seqWrMask) | (seqWrData & seqWrMask)) : memRdata;
		end
		else if (editSet_reg == activeSet_reg)
		begin
			seqActive_reg <= (seqActive_reg & ~seqWrMask) | (seqWrData & seqWrMask);
		end
	end

	// per line: pick the source, then invert after the level
	for (genvar i = 0; i < 2; i++)
	begin : g_line
		always_ff @(posedge sys_clk or negedge reset_n)
		begin
			if (!reset_n)
			begin
				lineOut_reg[i] <= 1'b0;
			end
			else
			begin
				lineOut_reg[i] <= pickSource(src_reg[i], camSig, staticLevel_reg[i],
					seqActive_reg[i]) ^ invert_reg[i];
			end
		end
	end

	// pin drives only in output mode; the spare bit has no enable
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pinEn_reg <= 1'b0;
		end
		else
		begin
			pinEn_reg <= lineModeOut_reg;
		end
	end

	// read mux on the live address so data are ready at the fire edge
	always_comb
	begin
		rdWord = 32'h0000_0000;
		case ({s_axi_araddr[7:2], 2'b00})
			`OSL_OFF_CTRL:
			begin
				rdWord[`OSL_CTRL_OUT]    = lineModeOut_reg;
				rdWord[`OSL_CTRL_INV_GP] = invert_reg[0];
				rdWord[`OSL_CTRL_INV_SP] = invert_reg[1];
			end
			`OSL_OFF_SRC_GP:  rdWord[2:0] = src_reg[0];
			`OSL_OFF_SRC_SP:  rdWord[2:0] = src_reg[1];
			`OSL_OFF_LVL_SEL: rdWord[0]   = levelSel_reg;
			`OSL_OFF_LVL_ONE: rdWord[0]   = staticLevel_reg[levelSel_reg];
			`OSL_OFF_LVL_ALL:
			begin
				rdWord[`OSL_BIT_GP] = staticLevel_reg[0];
				rdWord[`OSL_BIT_SP] = staticLevel_reg[1];
			end
			`OSL_OFF_SEQ_SEL: rdWord[0]   = seqSel_reg;
			`OSL_OFF_SEQ_ONE: rdWord[0]   = seqActive_reg[seqSel_reg];
			`OSL_OFF_SEQ_ALL:
			begin
				rdWord[`OSL_BIT_GP] = seqActive_reg[0];
				rdWord[`OSL_BIT_SP] = seqActive_reg[1];
			end
			`OSL_OFF_SET_SEL: rdWord[SET_W-1:0] = editSet_reg;
			`OSL_OFF_STATUS:
			begin
				rdWord[1:0] = lineOut_reg;
				rdWord[`OSL_STAT_SET_LSB +: SET_W] = activeSet_reg;
			end
			default: ;
		endcase
	end

	// read channel, one outstanding read
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			arReady_reg <= 1'b0;
			rValid_reg  <= 1'b0;
			rData_reg   <= 32'h0000_0000;
			rResp_reg   <= `OSL_RESP_OKAY;
		end
		else if (arFire)
		begin
			arReady_reg <= 1'b0;
			rValid_reg  <= 1'b1;
			rData_reg   <= rdWord;
			rResp_reg   <= isMapped(s_axi_araddr[7:0]) ? `OSL_RESP_OKAY : `OSL_RESP_SLVERR;
		end
		else if (rValid_reg && s_axi_rready)
		begin
			rValid_reg <= 1'b0;
		end
		else if (!rValid_reg)
		begin
			arReady_reg <= 1'b1;
		end
	end

	// outputs straight from flops
	assign s_axi_awready       = awReady_reg;
	assign s_axi_wready        = wReady_reg;
	assign s_axi_bvalid        = bValid_reg;
	assign s_axi_bresp         = bResp_reg;
	assign s_axi_arready       = arReady_reg;
	assign s_axi_rvalid        = rValid_reg;
	assign s_axi_rdata         = rData_reg;
	assign s_axi_rresp         = rResp_reg;
	assign generalPurposePin   = lineOut_reg[0];
	assign generalPurposePinEn = pinEn_reg;
	assign spareLinkBit        = lineOut_reg[1];

	// checks on the line and register behaviour
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	AST_GP_OE: assert property (!lineModeOut_reg |=> !generalPurposePinEn)
		else $error("pin enabled while not in output mode");
	AST_STATIC: assert property ((src_reg[0] == osl_pkg::SRC_USER && !invert_reg[0])
		|=> generalPurposePin == $past(staticLevel_reg[0]))
		else $error("pin does not follow its static level");
	AST_INV_SEQ: assert property ((src_reg[1] == osl_pkg::SRC_SYNC_USER && invert_reg[1])
		|=> spareLinkBit == !$past(seqActive_reg[1]))
		else $error("spare bit not inverted after sequenced level");
	AST_INV_SRC: assert property ((src_reg[1] == osl_pkg::SRC_EXPOSURE && invert_reg[1])
		|=> spareLinkBit != $past(exposureActive))
		else $error("inverted spare bit follows source directly");
	AST_STATIC_KEEP: assert property ((loadPending_reg && !wrFire)
		|=> $stable(staticLevel_reg))
		else $error("static levels changed by set load");
	AST_SEQ_LOAD: assert property (frameStartAdvance
		|-> ##2 activeSet_reg == $past(nextSetIndex, 2))
		else $error("active set not loaded two cycles after advance");
	AST_ALL_READ: assert property ((arFire && s_axi_araddr[7:0] == `OSL_OFF_LVL_ALL)
		|=> s_axi_rvalid && s_axi_rdata == {19'h0, $past(staticLevel_reg[1]), 11'h0,
		$past(staticLevel_reg[0])})
		else $error("combined static read wrong");
	AST_ALL_WRITE: assert property ((wrFire && wrOff == `OSL_OFF_LVL_ALL
		&& wStrb_reg[1:0] == 2'h3) |=> staticLevel_reg ==
		{$past(wData_reg[`OSL_BIT_SP]), $past(wData_reg[`OSL_BIT_GP])})
		else $error("combined static write not applied");
	AST_SEQ_ALL: assert property ((wrFire && wrOff == `OSL_OFF_SEQ_ALL
		&& wStrb_reg[1:0] == 2'h3 && editSet_reg == activeSet_reg && !loadPending_reg)
		|=> seqActive_reg == {$past(wData_reg[`OSL_BIT_SP]),
		$past(wData_reg[`OSL_BIT_GP])})
		else $error("combined sequenced write not applied");
	AST_BHOLD: assert property ((s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
		else $error("write response dropped before taken");

endmodule : osl_top

`default_nettype wire

/* verification/osl_line_sink.sv */
/*
 Receiver model standing on the far side of the output lines: a frame
 grabber or lamp driver that samples both lines on sys_clk.
 Assumes the camera lines are synchronous to sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module osl_line_sink (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic reset_n,
	// lines from the camera
	input  wire logic generalPurposePin,
	input  wire logic generalPurposePinEn,
	input  wire logic spareLinkBit,
	// levels as the receiver sees them
	output logic      gpSeen,
	output logic      spSeen
);
	// an undriven pin floats: flip each cycle so stale data never matches
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			gpSeen <= 1'b0;
			spSeen <= 1'b0;
		end
		else
		begin
			gpSeen <= generalPurposePinEn ? generalPurposePin : ~gpSeen;
			spSeen <= spareLinkBit;
		end
	end
endmodule : osl_line_sink

`default_nettype wire

/* verification/osl_top_tb.sv */
/*
 Self-checking bench of the output line selector: AXI4-Lite tasks and
 line checks through the receiver model.
 Assumes the default NUM_SETS of 16 and one 50 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none

`include "osl_cfg.svh"

`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
	$display("FAIL %s expected %h seen %h", nm, exp, got); end end

module osl_top_tb;
	// bench drives
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  awaddr  = 8'h00;
	logic [7:0]  araddr  = 8'h00;
	logic [31:0] wdata   = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic [3:0]  cam     = 4'h0;
	logic        adv     = 1'b0;
	logic [3:0]  nextSet = 4'h0;
	// design outputs and bench state
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, bResp, rResp;
	logic [31:0] s_axi_rdata, rData;
	logic        gpPin, gpEn, spBit, gpSeen, spSeen;
	int          num_errors = 0;
	int          cmp_count  = 0;
	int          cycles     = 0;

	osl_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(rready), .acqTriggerWait(cam[0]), .frameTriggerWait(cam[1]),
		.exposureActive(cam[2]), .frameCycle(cam[3]), .frameStartAdvance(adv),
		.nextSetIndex(nextSet), .generalPurposePin(gpPin), .generalPurposePinEn(gpEn),
		.spareLinkBit(spBit));

	osl_line_sink sink (.sys_clk(sys_clk), .reset_n(reset_n), .generalPurposePin(gpPin),
		.generalPurposePinEn(gpEn), .spareLinkBit(spBit), .gpSeen(gpSeen), .spSeen(spSeen));

	// 50 MHz clock
	initial
	begin
		forever #10 sys_clk = ~sys_clk;
	end

	// hang guard, far above the few hundred cycles the tests need
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		begin
			$display("errors %0d of %0d comparisons", num_errors, cmp_count);
			if (num_errors == 0 && cmp_count > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask : end_of_test

	task automatic cyc(input int n);
		begin
			repeat (n) @(posedge sys_clk);
		end
	endtask : cyc

	// address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		begin
			@(posedge sys_clk);
			awaddr  <= a;
			wdata   <= d;
			awvalid <= 1'b1;
			wvalid  <= 1'b1;
			do
			begin
				@(posedge sys_clk);
				if (awvalid && s_axi_awready === 1'b1)
					awvalid <= 1'b0;
				if (wvalid && s_axi_wready === 1'b1)
					wvalid <= 1'b0;
				// late ready makes the response wait one edge
				if (s_axi_bvalid === 1'b1 && !bready)
					bready <= 1'b1;
			end
			while (!(s_axi_bvalid === 1'b1 && bready));
			bResp  = s_axi_bresp;
			bready <= 1'b0;
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		begin
			@(posedge sys_clk);
			araddr  <= a;
			arvalid <= 1'b1;
			rready  <= 1'b1;
			do
			begin
				@(posedge sys_clk);
				if (arvalid && s_axi_arready === 1'b1)
					arvalid <= 1'b0;
			end
			while (!(s_axi_rvalid === 1'b1 && rready));
			rData  = s_axi_rdata;
			rResp  = s_axi_rresp;
			rready <= 1'b0;
		end
	endtask : axi_rd

	// lines settle within three edges, the receiver adds one more
	task automatic chk_lines(input logic gp, input logic sp);
		begin
			cyc(6);
			`CHK("pin", gp, gpSeen)
			`CHK("spare", sp, spSeen)
		end
	endtask : chk_lines

	task automatic advance(input logic [3:0] k);
		begin
			@(posedge sys_clk);
			adv     <= 1'b1;
			nextSet <= k;
			@(posedge sys_clk);
			adv     <= 1'b0;
		end
	endtask : advance

	// main sequence
	initial
	begin
		cyc(12);
		reset_n <= 1'b1;
		cyc(2);
		axi_rd(`OSL_OFF_LVL_ALL);
		`CHK("lvl_all", 32'h0, rData)
		axi_rd(`OSL_OFF_SEQ_ALL);
		`CHK("seq_all", 32'h0, rData)
		axi_wr(`OSL_OFF_CTRL, 32'h1);
		`CHK("bresp", 2'h0, bResp)
		chk_lines(1'h0, 1'h0);
		// each status source, the two lines on different choices
		for (int c = 0; c < 4; c++)
		begin
			axi_wr(`OSL_OFF_SRC_GP, 32'(c));
			axi_wr(`OSL_OFF_SRC_SP, 32'((c + 1) % 4));
			cam <= 4'h1 << c;
			chk_lines(1'h1, 1'h0);
			cam <= ~(4'h1 << c);
			chk_lines(1'h0, 1'h1);
		end
		// static levels, single and combined
		axi_wr(`OSL_OFF_SRC_GP, 32'h4);
		axi_wr(`OSL_OFF_SRC_SP, 32'h4);
		axi_wr(`OSL_OFF_LVL_SEL, 32'h0);
		axi_wr(`OSL_OFF_LVL_ONE, 32'h1);
		chk_lines(1'h1, 1'h0);
		axi_wr(`OSL_OFF_LVL_SEL, 32'h1);
		axi_wr(`OSL_OFF_LVL_ONE, 32'h1);
		axi_rd(`OSL_OFF_LVL_ONE);
		`CHK("lvl_one", 32'h1, rData)
		axi_rd(`OSL_OFF_LVL_ALL);
		`CHK("lvl_all", 32'h1001, rData)
		axi_wr(`OSL_OFF_LVL_ALL, 32'hFFFFEFFE);
		axi_rd(`OSL_OFF_LVL_ALL);
		`CHK("lvl_all", 32'h0, rData)
		axi_wr(`OSL_OFF_LVL_ALL, 32'h00001000);
		chk_lines(1'h0, 1'h1);
		// inversion after the user level
		axi_wr(`OSL_OFF_CTRL, 32'h7);
		chk_lines(1'h1, 1'h0);
		axi_rd(`OSL_OFF_LVL_ALL);
		`CHK("lvl_all", 32'h1000, rData)
		// pin released when not output, spare still driven
		axi_wr(`OSL_OFF_CTRL, 32'h0);
		cyc(3);
		`CHK("pin_en", 1'h0, gpEn)
		`CHK("spare", 1'h1, spSeen)
		axi_wr(`OSL_OFF_CTRL, 32'h1);
		cyc(3);
		`CHK("pin_en", 1'h1, gpEn)
		// sequenced levels: edit set 3 while set 0 is live
		axi_wr(`OSL_OFF_SRC_GP, 32'h5);
		axi_wr(`OSL_OFF_SRC_SP, 32'h5);
		axi_wr(`OSL_OFF_SET_SEL, 32'h3);
		axi_wr(`OSL_OFF_SEQ_ALL, 32'hFFFFFFFF);
		axi_rd(`OSL_OFF_SEQ_ALL);
		`CHK("seq_all", 32'h0, rData)
		chk_lines(1'h0, 1'h0);
		advance(4'h3);
		chk_lines(1'h1, 1'h1);
		axi_rd(`OSL_OFF_SEQ_ALL);
		`CHK("seq_all", 32'h1001, rData)
		axi_rd(`OSL_OFF_LVL_ALL);
		`CHK("lvl_all", 32'h1000, rData)
		axi_rd(`OSL_OFF_STATUS);
		`CHK("active_set", 8'h03, rData[15:8])
		axi_wr(`OSL_OFF_SEQ_SEL, 32'h1);
		axi_wr(`OSL_OFF_SEQ_ONE, 32'h0);
		chk_lines(1'h1, 1'h0);
		axi_rd(`OSL_OFF_SEQ_ALL);
		`CHK("seq_all", 32'h1, rData)
		axi_wr(`OSL_OFF_CTRL, 32'h7);
		chk_lines(1'h0, 1'h1);
		advance(4'h0);
		chk_lines(1'h1, 1'h1);
		axi_rd(`OSL_OFF_LVL_ALL);
		`CHK("lvl_all", 32'h1000, rData)
		// live set edited in place; spare inverted on a status source
		axi_wr(`OSL_OFF_SET_SEL, 32'h0);
		axi_wr(`OSL_OFF_SEQ_ALL, 32'h00001000);
		chk_lines(1'h1, 1'h0);
		axi_wr(`OSL_OFF_SRC_SP, 32'h2);
		cam <= 4'h4;
		chk_lines(1'h1, 1'h0);
		cam <= 4'h0;
		chk_lines(1'h1, 1'h1);
		cam <= 4'hF;
		axi_wr(`OSL_OFF_SRC_SP, 32'h6);
		chk_lines(1'h1, 1'h1);
		// unmapped offset refused both ways
		axi_wr(8'h3C, 32'hFFFFFFFF);
		`CHK("bresp", 2'h2, bResp)
		axi_rd(8'h3C);
		`CHK("rresp", 2'h2, rResp)
		`CHK("rdata", 32'h0, rData)
		end_of_test();
	end
endmodule : osl_top_tb

`undef CHK
`default_nettype wire
